// ### hdl/rsp_pwm_top.v
// Contract
// RULE_01: Period-match clear code clears channel 3 counter.
// RULE_02: Edge select 00 counts rising edges.
// RULE_03: Prescaler code 001 divides clock by four.
// RULE_04: Channel 4 follows channel 3 settings.
// RULE_05: Mode code 1000 selects reset-synchronized PWM.
// RULE_06: Buffer bits pair C/D with A/B.
// RULE_07: Software keeps channel 4 buffer bits zero.
// RULE_08: Period register is counter upper limit.
// RULE_09: Duty registers map to output pairs one-three.
// RULE_10: Software preloads buffers equal to compares.
// RULE_11: Toggle enable inverts extra output per period.
// RULE_12: Lock clear allows level and source writes.
// RULE_13: Source zero takes levels from control one.
// RULE_14: Inverse level one: start low, active high.
// RULE_15: Positive level one: start low, active high.
// RULE_16: Master enable bit gates each pin drive.
// RULE_17: Compare interrupt enable raises request on flag.
// RULE_18: Channel 3 start runs both counters.
// RULE_19: Software never sets channel 4 start.
// RULE_20: Sixteen-bit counters, software zeroes before start.
// RULE_21: Period match copies buffers into compares.
// RULE_22: Clear in last state, period plus one.
// RULE_23: Zero duty pulses; duty over period toggles.
// RULE_24: Active at duty match, inactive at period.
`timescale 1ns/1ns
`include "rsp_consts.vh"
module rsp_pwm_top (
	input wire clk_i, // 125 MHz system clock
	input wire rst_i, // Sync reset, high
	input wire [31:0] wb_adr_i, // Byte address
	input wire [31:0] wb_dat_i, // Write data
	output wire [31:0] wb_dat_o, // Read data
	input wire wb_we_i, // Write enable
	input wire [3:0] wb_sel_i, // Byte lanes
	input wire wb_cyc_i, // Cycle
	input wire wb_stb_i, // Strobe
	output wire wb_ack_o, // Acknowledge
	output wire irq_o, // Period compare request
	output wire period_toggle_pin_o, // Per-period toggle
	output wire phase1_pos_pin_o, // Phase 1 positive
	output wire phase1_pos_pin_oe_o, // Phase 1 positive drive
	output wire phase2_pos_pin_o, // Phase 2 positive
	output wire phase2_pos_pin_oe_o, // Phase 2 positive drive
	output wire phase3_pos_pin_o, // Phase 3 positive
	output wire phase3_pos_pin_oe_o, // Phase 3 positive drive
	output wire phase1_neg_pin_o, // Phase 1 inverse
	output wire phase1_neg_pin_oe_o, // Phase 1 inverse drive
	output wire phase2_neg_pin_o, // Phase 2 inverse
	output wire phase2_neg_pin_oe_o, // Phase 2 inverse drive
	output wire phase3_neg_pin_o, // Phase 3 inverse
	output wire phase3_neg_pin_oe_o // Phase 3 inverse drive
);
	function [7:0] idx;
		input [31:0] off;
		begin
			idx = off[7:0];
		end
	endfunction

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] dat;
		input [3:0] sel;
		begin
			merge16 = {sel[1] ? dat[15:8] : old[15:8],
				sel[0] ? dat[7:0] : old[7:0]};
		end
	endfunction

	reg ack_q;
	reg [31:0] dat_q;
	reg [7:0] ctl3_q;
	reg [7:0] ctl4_q;
	reg [7:0] mode3_q;
	reg [7:0] mode4_q;
	reg [7:0] ier3_q;
	reg [7:0] output_master_enable_q;
	reg [7:0] ocr1_q;
	reg [7:0] start_q;
	reg flag_q;
	reg [15:0] cnt3_q;
	reg [15:0] cnt4_q;
	reg [15:0] per_q;
	reg [15:0] pbuf_q;
	reg tog_q;
	reg ran_q;
	reg [5:0] pin_q;
	reg [31:0] rd_d;

	wire [7:0] widx;
	wire req;
	wire wr_go;
	wire lo_wr;
	wire rsp;
	wire run3;
	wire run4;
	wire tick;
	wire pmatch;
	wire clr3;
	wire bfa;
	wire bfb;
	wire [47:0] duty_w;
	wire [47:0] dbuf_w;
	wire [2:0] act_w;
	wire [5:0] lvl_w;
	wire [2:0] neg_act_w;

	assign widx = wb_adr_i[9:2];
	assign req = wb_cyc_i & wb_stb_i;
	// Write lands on the edge where the master sees ack
	assign wr_go = req & wb_we_i & ack_q;
	// Byte registers live in lane 0; other lanes alone change nothing
	assign lo_wr = wr_go & wb_sel_i[0];

	assign rsp = (mode3_q[`RSP_F_MD] == `RSP_MD_RSP); // see RULE_05
	assign run3 = start_q[`RSP_B_CH3_COUNT_START];
	// Channel 4 start bit has no effect in this mode
	assign run4 = rsp ? start_q[`RSP_B_CH3_COUNT_START] : start_q[`RSP_B_CH4_COUNT_START]; // see RULE_18
	// Channel 4 buffer bits are ignored; pairing follows channel 3
	assign bfa = mode3_q[`RSP_B_BFA]; // see RULE_04
	assign bfb = mode3_q[`RSP_B_BFB]; // see RULE_06
	assign pmatch = tick & run3 & (cnt3_q == per_q); // see RULE_08
	assign clr3 = pmatch & (ctl3_q[`RSP_F_COUNTER_CLEAR_SELECT] == `RSP_COUNTER_CLEAR_SELECT_PER); // see RULE_01

	// One divider serves both channels, so their counts stay in step
	rsp_prescaler u_presc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run3 | run4),
		.sel_i(ctl3_q[`RSP_F_PRESCALER_SELECT]),
		.edge_i(ctl3_q[`RSP_F_CLOCK_EDGE_SELECT]),
		.tick_o(tick)
	);

	// Bus slave: ack one cycle after request, dropped the cycle after
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (req & ~ack_q)
				dat_q <= rd_d;
		end
	end
	assign wb_ack_o = ack_q;
	// Data is taken a cycle before ack, so a running counter may read one count behind
	assign wb_dat_o = dat_q;

	// Control registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctl3_q <= `RSP_RST_8;
			ctl4_q <= `RSP_RST_8;
			mode3_q <= `RSP_RST_8;
			mode4_q <= `RSP_RST_8;
			ier3_q <= `RSP_RST_8;
			output_master_enable_q <= `RSP_RST_8;
			ocr1_q <= `RSP_RST_8;
			start_q <= `RSP_RST_8;
		end else if (lo_wr) begin
			case (widx)
				idx(`RSP_A_CTL3): ctl3_q <= wb_dat_i[7:0];
				idx(`RSP_A_CTL4): ctl4_q <= wb_dat_i[7:0];
				idx(`RSP_A_MODE3): mode3_q <= wb_dat_i[7:0];
				idx(`RSP_A_MODE4): mode4_q <= wb_dat_i[7:0];
				idx(`RSP_A_IER3): ier3_q <= {7'h0, wb_dat_i[`RSP_B_IRQEN]};
				idx(`RSP_A_OUTPUT_MASTER_ENABLE): output_master_enable_q <= {2'h0, wb_dat_i[5:0]};
				idx(`RSP_A_OCR1): begin
					ocr1_q[`RSP_B_PERIOD_TOGGLE_ENABLE] <= wb_dat_i[`RSP_B_PERIOD_TOGGLE_ENABLE];
					// Lock is sticky until reset
					ocr1_q[`RSP_B_OUTPUT_CONTROL_LOCK] <= ocr1_q[`RSP_B_OUTPUT_CONTROL_LOCK] | wb_dat_i[`RSP_B_OUTPUT_CONTROL_LOCK];
					if (!ocr1_q[`RSP_B_OUTPUT_CONTROL_LOCK])
						ocr1_q[2:0] <= wb_dat_i[2:0]; // see RULE_12
				end
				// Channel 4 start is kept, but counts only outside this mode
				idx(`RSP_A_START): start_q <= {wb_dat_i[7:6], 6'h0};
				default: ctl3_q <= ctl3_q;
			endcase
		end
	end

	// Compare flag: a match in the clearing cycle still sets it
	always @(posedge clk_i) begin
		if (rst_i)
			flag_q <= 1'b0;
		else if (pmatch)
			flag_q <= 1'b1;
		// Only a written 0 clears; a written 1 leaves the flag alone
		else if (lo_wr && widx == idx(`RSP_A_STAT3) && !wb_dat_i[`RSP_B_FLAG])
			flag_q <= 1'b0;
	end
	// Level request; stays up until the flag or the enable is cleared
	assign irq_o = flag_q & ier3_q[`RSP_B_IRQEN]; // see RULE_17

	// Counters; a software write wins over counting
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt3_q <= `RSP_RST_16;
			cnt4_q <= `RSP_RST_16;
		end else begin
			if (wr_go && widx == idx(`RSP_A_CNT3))
				cnt3_q <= merge16(cnt3_q, wb_dat_i, wb_sel_i); // see RULE_20
			else if (tick && run3)
				cnt3_q <= clr3 ? `RSP_RST_16 : cnt3_q + 16'h0001; // see RULE_22
			// In this mode channel 4 clears with channel 3; all three phases compare against the channel 3 count
			if (wr_go && widx == idx(`RSP_A_CNT4))
				cnt4_q <= merge16(cnt4_q, wb_dat_i, wb_sel_i);
			else if (tick && run4)
				cnt4_q <= (rsp && clr3) ? `RSP_RST_16 : cnt4_q + 16'h0001; // see RULE_04
		end
	end

	// Period and its buffer
	always @(posedge clk_i) begin
		if (rst_i) begin
			per_q <= `RSP_RST_GR;
			pbuf_q <= `RSP_RST_GR;
		end else begin
			if (wr_go && widx == idx(`RSP_A_PBUF))
				pbuf_q <= merge16(pbuf_q, wb_dat_i, wb_sel_i);
			// A buffer written in the transfer cycle is too late; the old value moves
			if (wr_go && widx == idx(`RSP_A_PER))
				per_q <= merge16(per_q, wb_dat_i, wb_sel_i);
			else if (pmatch && bfa)
				per_q <= pbuf_q; // see RULE_21
		end
	end

	// Per-phase duty, buffer and active state
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : ph
			localparam [31:0] DA = (i == 0) ? `RSP_A_DUTY1 : (i == 1) ? `RSP_A_DUTY2 : `RSP_A_DUTY3;
			localparam [31:0] BA = (i == 0) ? `RSP_A_DBUF1 : (i == 1) ? `RSP_A_DBUF2 : `RSP_A_DBUF3;
			reg [15:0] duty_q;
			reg [15:0] dbuf_q;
			reg act_q;
			wire buf_en;

			// Phase 2 sits on an A register, the others on B
			assign buf_en = (i == 1) ? bfa : bfb; // see RULE_06
			assign duty_w[16*i+:16] = duty_q; // see RULE_09
			assign dbuf_w[16*i+:16] = dbuf_q;
			assign act_w[i] = act_q;

			always @(posedge clk_i) begin
				if (rst_i) begin
					duty_q <= `RSP_RST_GR;
					dbuf_q <= `RSP_RST_GR;
				end else begin
					if (wr_go && widx == DA[7:0])
						duty_q <= merge16(duty_q, wb_dat_i, wb_sel_i);
					else if (pmatch && buf_en)
						duty_q <= dbuf_q; // see RULE_21
					if (wr_go && widx == BA[7:0])
						dbuf_q <= merge16(dbuf_q, wb_dat_i, wb_sel_i);
				end
			end

			// Duty at or past period never matches alone, so it toggles
			always @(posedge clk_i) begin
				if (rst_i || !rsp)
					act_q <= 1'b0;
				else if (pmatch)
					act_q <= (duty_q >= per_q) ? ~act_q : 1'b0; // see RULE_23
				// A duty moved below the count waits for the next period
				else if (tick && run3 && cnt3_q == duty_q)
					act_q <= 1'b1; // see RULE_24
			end
		end
	endgenerate

	// Inverse stays at its initial level until the first start
	always @(posedge clk_i) begin
		if (rst_i || !rsp) begin
			ran_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			if (run3)
				ran_q <= 1'b1;
			if (pmatch && ocr1_q[`RSP_B_PERIOD_TOGGLE_ENABLE])
				tog_q <= ~tog_q; // see RULE_11
		end
	end

	// Inverse is active while its positive side idles, once the counter has run
	assign neg_act_w = ~act_w & {3{ran_q}};
	// Only one output control set exists, so the source bit selects it either way
	assign lvl_w[2:0] = ocr1_q[`RSP_B_POSITIVE_LEVEL_SELECT] ? act_w : ~act_w; // see RULE_15
	assign lvl_w[5:3] = ocr1_q[`RSP_B_INVERSE_LEVEL_SELECT] ? neg_act_w : ~neg_act_w; // see RULE_14

	// Registered so compare glitches never reach the pins
	always @(posedge clk_i) begin
		if (rst_i)
			pin_q <= 6'h00;
		else
			pin_q <= lvl_w; // see RULE_13
	end

	assign period_toggle_pin_o = tog_q;
	assign phase1_pos_pin_o = pin_q[0];
	assign phase2_pos_pin_o = pin_q[1];
	assign phase3_pos_pin_o = pin_q[2];
	assign phase1_neg_pin_o = pin_q[3];
	assign phase2_neg_pin_o = pin_q[4];
	assign phase3_neg_pin_o = pin_q[5];

	// Enables come straight from the master enable bits; levels run on when off
	assign phase1_pos_pin_oe_o = output_master_enable_q[0]; // see RULE_16
	assign phase2_pos_pin_oe_o = output_master_enable_q[1];
	assign phase3_pos_pin_oe_o = output_master_enable_q[2];
	assign phase1_neg_pin_oe_o = output_master_enable_q[3];
	assign phase2_neg_pin_oe_o = output_master_enable_q[4];
	assign phase3_neg_pin_oe_o = output_master_enable_q[5];

	// Read mux; unmapped words read zero
	always @* begin
		rd_d = 32'h0000_0000;
		case (widx)
			idx(`RSP_A_CTL3): rd_d[7:0] = ctl3_q;
			idx(`RSP_A_CTL4): rd_d[7:0] = ctl4_q;
			idx(`RSP_A_MODE3): rd_d[7:0] = mode3_q;
			idx(`RSP_A_MODE4): rd_d[7:0] = mode4_q;
			idx(`RSP_A_STAT3): rd_d[0] = flag_q;
			idx(`RSP_A_IER3): rd_d[7:0] = ier3_q;
			idx(`RSP_A_OUTPUT_MASTER_ENABLE): rd_d[7:0] = output_master_enable_q;
			idx(`RSP_A_OCR1): rd_d[7:0] = {1'b0, ocr1_q[6], 2'h0, ocr1_q[3:0]};
			idx(`RSP_A_CNT3): rd_d[15:0] = cnt3_q;
			idx(`RSP_A_CNT4): rd_d[15:0] = cnt4_q;
			idx(`RSP_A_PER): rd_d[15:0] = per_q;
			idx(`RSP_A_PBUF): rd_d[15:0] = pbuf_q;
			idx(`RSP_A_DUTY1): rd_d[15:0] = duty_w[15:0];
			idx(`RSP_A_DUTY2): rd_d[15:0] = duty_w[31:16];
			idx(`RSP_A_DUTY3): rd_d[15:0] = duty_w[47:32];
			idx(`RSP_A_DBUF1): rd_d[15:0] = dbuf_w[15:0];
			idx(`RSP_A_DBUF2): rd_d[15:0] = dbuf_w[31:16];
			idx(`RSP_A_DBUF3): rd_d[15:0] = dbuf_w[47:32];
			idx(`RSP_A_START): rd_d[7:0] = start_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end
endmodule // rsp_pwm_top

// ### inc/rsp_consts.vh
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH

// Register offsets; word index is the low byte, byte address is four times it
`define RSP_A_CTL3 32'hFFFF_C200
`define RSP_A_CTL4 32'hFFFF_C201
`define RSP_A_MODE3 32'hFFFF_C202
`define RSP_A_MODE4 32'hFFFF_C203
`define RSP_A_STAT3 32'hFFFF_C205
`define RSP_A_IER3 32'hFFFF_C208
`define RSP_A_OUTPUT_MASTER_ENABLE 32'hFFFF_C20A
`define RSP_A_OCR1 32'hFFFF_C20E
`define RSP_A_CNT3 32'hFFFF_C210
`define RSP_A_CNT4 32'hFFFF_C212
`define RSP_A_PER 32'hFFFF_C218
`define RSP_A_DUTY1 32'hFFFF_C21A
`define RSP_A_DUTY2 32'hFFFF_C21C
`define RSP_A_DUTY3 32'hFFFF_C21E
`define RSP_A_PBUF 32'hFFFF_C224
`define RSP_A_DBUF1 32'hFFFF_C226
`define RSP_A_DBUF2 32'hFFFF_C228
`define RSP_A_DBUF3 32'hFFFF_C22A
`define RSP_A_START 32'hFFFF_C280

// Field positions
`define RSP_F_COUNTER_CLEAR_SELECT 7:5
`define RSP_F_CLOCK_EDGE_SELECT 4:3
`define RSP_F_PRESCALER_SELECT 2:0
`define RSP_F_MD 3:0
`define RSP_B_BFA 4
`define RSP_B_BFB 5
`define RSP_B_IRQEN 0
`define RSP_B_FLAG 0
`define RSP_B_PERIOD_TOGGLE_ENABLE 6
`define RSP_B_OUTPUT_CONTROL_LOCK 3
`define RSP_B_OUTPUT_LEVEL_SOURCE 2
`define RSP_B_INVERSE_LEVEL_SELECT 1
`define RSP_B_POSITIVE_LEVEL_SELECT 0
`define RSP_B_CH3_COUNT_START 6
`define RSP_B_CH4_COUNT_START 7

// Codes
`define RSP_COUNTER_CLEAR_SELECT_PER 3'h1
`define RSP_CLOCK_EDGE_SELECT_RISE 2'h0
`define RSP_CLOCK_EDGE_SELECT_FALL 2'h1
`define RSP_PRESCALER_SELECT_DIV1 3'h0
`define RSP_PRESCALER_SELECT_DIV4 3'h1
`define RSP_PRESCALER_SELECT_DIV16 3'h2
`define RSP_PRESCALER_SELECT_DIV64 3'h3
`define RSP_MD_RSP 4'h8

// Prescaler terminal counts (divide ratio minus one)
`define RSP_DIV1_LAST 6'h0
`define RSP_DIV4_LAST 6'h3
`define RSP_DIV16_LAST 6'hF
`define RSP_DIV64_LAST 6'h3F

// Reset values
`define RSP_RST_8 8'h00
`define RSP_RST_16 16'h0000
`define RSP_RST_GR 16'hFFFF

`endif

// ### hdl/rsp_prescaler.v
`timescale 1ns/1ns
`include "rsp_consts.vh"
module rsp_prescaler (
	input wire clk_i, // System clock
	input wire rst_i, // Sync reset, high
	input wire run_i, // Counter running
	input wire [2:0] sel_i, // Divide select
	input wire [1:0] edge_i, // Edge select
	output wire tick_o // One-cycle count enable
);
	reg [5:0] div_q;
	reg [5:0] last;
	wire rise;
	wire fall;

	always @* begin
		case (sel_i)
			`RSP_PRESCALER_SELECT_DIV1: last = `RSP_DIV1_LAST;
			`RSP_PRESCALER_SELECT_DIV4: last = `RSP_DIV4_LAST; // see RULE_03
			`RSP_PRESCALER_SELECT_DIV16: last = `RSP_DIV16_LAST;
			`RSP_PRESCALER_SELECT_DIV64: last = `RSP_DIV64_LAST;
			default: last = `RSP_DIV1_LAST;
		endcase
	end

	// Restart phase on stop so the first count after start is predictable
	always @(posedge clk_i) begin
		if (rst_i || !run_i || div_q >= last)
			div_q <= 6'h0;
		else
			div_q <= div_q + 6'h1;
	end

	assign rise = (div_q == last);
	assign fall = (div_q == (last >> 1));
	// Divided clock rises at wrap and falls at half way
	assign tick_o = (edge_i == `RSP_CLOCK_EDGE_SELECT_RISE) ? rise : // see RULE_02
		(edge_i == `RSP_CLOCK_EDGE_SELECT_FALL) ? fall : (rise | fall);
endmodule // rsp_prescaler

// ### tb/rsp_pwm_assertions.sv
`timescale 1ns/1ns
module rsp_pwm_assertions (
	input wire clk_i, // System clock
	input wire rst_i, // Sync reset, high
	input wire wb_we_i, // Write enable
	input wire wb_cyc_i, // Cycle
	input wire wb_stb_i, // Strobe
	input wire wb_ack_o, // Acknowledge
	input wire irq_o, // Compare request
	input wire period_toggle_pin_o, // Per-period toggle
	input wire phase1_pos_pin_o, // Phase 1 positive
	input wire phase1_pos_pin_oe_o, // Phase 1 positive drive
	input wire phase2_pos_pin_oe_o, // Phase 2 positive drive
	input wire phase3_pos_pin_oe_o, // Phase 3 positive drive
	input wire phase1_neg_pin_oe_o, // Phase 1 inverse drive
	input wire phase2_neg_pin_oe_o, // Phase 2 inverse drive
	input wire phase3_neg_pin_oe_o, // Phase 3 inverse drive
	input wire [31:0] wb_adr_i, // Byte address
	input wire [31:0] wb_dat_i, // Write data
	input wire [31:0] wb_dat_o // Read data
);
	wire [5:0] oe = {phase3_neg_pin_oe_o, phase2_neg_pin_oe_o, phase1_neg_pin_oe_o,
		phase3_pos_pin_oe_o, phase2_pos_pin_oe_o, phase1_pos_pin_oe_o};
	wire rd = wb_ack_o && !wb_we_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_rise; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack missing after request");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_oe_write; wb_ack_o && wb_we_i && wb_adr_i[9:2] == 8'h0a |=> oe == $past(wb_dat_i[5:0]); endproperty
	a_oe_write: assert property (p_oe_write) else $error("drive enables differ from write");
	property p_oe_hold; $changed(oe) |-> $past(wb_ack_o && wb_we_i); endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("drive enables moved without write");
	property p_oe_read; rd && wb_adr_i[9:2] == 8'h0a |-> wb_dat_o == {26'h0, oe}; endproperty
	a_oe_read: assert property (p_oe_read) else $error("enable register read wrong");
	property p_unmapped; rd && wb_adr_i[9:2] == 8'h7f |-> wb_dat_o == 32'h0000_0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_irq_fall; $fell(irq_o) |-> $past(wb_ack_o && wb_we_i); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("request dropped without write");
	// Period is never below four counts here, so a shorter gap is a fault
	property p_tgl_gap; $changed(period_toggle_pin_o) |=> $stable(period_toggle_pin_o)[*3]; endproperty
	a_tgl_gap: assert property (p_tgl_gap) else $error("toggle output flips too fast");
	c_irq: cover property ($rose(irq_o));
	c_tgl: cover property ($changed(period_toggle_pin_o));
	c_p1: cover property ($rose(phase1_pos_pin_o));
endmodule // rsp_pwm_assertions
bind rsp_pwm_top rsp_pwm_assertions rsp_pwm_assertions_i (.clk_i, .rst_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .irq_o, .period_toggle_pin_o, .phase1_pos_pin_o, .phase1_pos_pin_oe_o, .phase2_pos_pin_oe_o,
	.phase3_pos_pin_oe_o, .phase1_neg_pin_oe_o, .phase2_neg_pin_oe_o, .phase3_neg_pin_oe_o, .wb_adr_i,
	.wb_dat_i, .wb_dat_o);

// ### tb/rsp_gate_model.sv
`timescale 1ns/1ns
module rsp_gate_model (
	input wire clk_i, // Sample clock
	input wire [2:0] pos_i, // High-side commands
	input wire [2:0] neg_i, // Low-side commands
	input wire [5:0] oe_i, // Pin drive enables
	output logic [5:0] lvl_o, // Levels at the driver
	output logic shoot_o // Both switches of a leg on
);
	logic [5:0] last_q = 6'h00;
	// Released pins wander so a stale level never passes
	always_comb lvl_o = (oe_i & {neg_i, pos_i}) | (~oe_i & ~last_q);
	always @(posedge clk_i) last_q <= lvl_o;
	always_comb shoot_o = |(lvl_o[2:0] & lvl_o[5:3] & oe_i[2:0] & oe_i[5:3]);
endmodule // rsp_gate_model

// ### tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg cyc = 1'b0, stb = 1'b0, we = 1'b0;
	reg [3:0] sel = 4'h0, ln = 4'hf;
	reg [31:0] adr = 32'h0000_0000, dat = 32'h0000_0000;
	wire [31:0] dat_o;
	wire [5:0] oe, lvl;
	wire [2:0] pos, neg;
	wire ack, irq, tgl, shoot;
	wire [6:0] mon = {tgl, lvl};
	int bad_count = 0, cmp_count = 0, i;
	logic [31:0] exp_q[$];
	logic [31:0] s = 32'h0000_b949, r, ev;
	logic [15:0] d1;
	logic [15:0] cv[16];
	logic [7:0] ix[6] = '{8'h0a, 8'h18, 8'h1a, 8'h24, 8'h03, 8'h7f};
	logic [15:0] rv[6] = '{16'h0000, 16'hffff, 16'hffff, 16'hffff, 16'h0000, 16'h0000};
	logic [7:0] gx[6] = '{8'h1a, 8'h1c, 8'h1e, 8'h26, 8'h28, 8'h2a};
	logic [7:0] cx[16] = '{8'h02, 8'h00, 8'h18, 8'h24, 8'h1a, 8'h26, 8'h1c, 8'h28, 8'h1e, 8'h2a, 8'h10, 8'h12,
		8'h0e, 8'h0a, 8'h08, 8'h80};
	localparam [15:0] P = 16'h000f;
	always #4 clk_i = ~clk_i;
	rsp_pwm_top rsp_pwm_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq_o(irq),
		.period_toggle_pin_o(tgl), .phase1_pos_pin_o(pos[0]), .phase1_pos_pin_oe_o(oe[0]), .phase2_pos_pin_o(pos[1]),
		.phase2_pos_pin_oe_o(oe[1]), .phase3_pos_pin_o(pos[2]), .phase3_pos_pin_oe_o(oe[2]), .phase1_neg_pin_o(neg[0]),
		.phase1_neg_pin_oe_o(oe[3]), .phase2_neg_pin_o(neg[1]), .phase2_neg_pin_oe_o(oe[4]),
		.phase3_neg_pin_o(neg[2]), .phase3_neg_pin_oe_o(oe[5]));
	rsp_gate_model rsp_gate_model_i (.clk_i(clk_i), .pos_i(pos), .neg_i(neg), .oe_i(oe), .lvl_o(lvl), .shoot_o(shoot));
	function [31:0] xs;
		begin
			s = s ^ (s << 13);
			s = s ^ (s >> 17);
			s = s ^ (s << 5);
			xs = s;
		end
	endfunction
	function [31:0] ba(input [7:0] ix_i);
		ba = {22'h00_0000, ix_i, 2'h0};
	endfunction
	task complete_run;
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// One idle cycle before each request keeps ack pairing unambiguous
	task wb(input [31:0] a, input w, input [31:0] d, input [31:0] e);
		int n;
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			sel <= ln;
			n = 0;
			if (!w) exp_q.push_back(e);
			do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
			if (n >= 20) bad_count++;
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
			sel <= 4'h0;
		end
	endtask
	// Full high time of a monitored level, in clock cycles
	task width(input int k, input int e);
		int m;
		begin
			m = 0;
			while (mon[k] !== 1'b0 && m < 3000) begin @(posedge clk_i); m++; end
			while (mon[k] !== 1'b1 && m < 3000) begin @(posedge clk_i); m++; end
			m = 0;
			while (mon[k] === 1'b1 && m < 3000) begin @(posedge clk_i); m++; end
			`CHK(m, e)
		end
	endtask
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) bad_count++;
			else begin
				ev = exp_q.pop_front();
				`CHK(dat_o, ev)
			end
		end
		if (shoot === 1'b1) `CHK(shoot, 1'b0)
	end
	initial begin
		#300000;
		bad_count++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 6; i++) wb(ba(ix[i]), 1'b0, 0, {16'h0000, rv[i]});
		for (i = 0; i < 6; i++) begin
			r = xs();
			wb(ba(gx[i]), 1'b1, r, 0);
			wb(ba(gx[i]), 1'b0, 0, {16'h0000, r[15:0]});
		end
		d1 = {13'h0000, r[2:0]} + 16'h0001;
		cv = '{16'h0038, 16'h0021, P, P, d1, d1, 16'h0002, 16'h0002, P, P, 16'h0000, 16'h0000,
			16'h0043, 16'h003f, 16'h0001, 16'h0040};
		for (i = 0; i < 16; i++) wb(ba(cx[i]), 1'b1, {16'h0000, cv[i]}, 0);
		width(6, (P + 1) * 4);
		width(0, (P - d1) * 4);
		width(1, (P - 2) * 4);
		width(2, (P + 1) * 4);
		width(3, (d1 + 1) * 4);
		wb(ba(8'h26), 1'b1, 0, 0);
		width(6, (P + 1) * 4);
		width(0, P * 4);
		wb(ba(8'h1a), 1'b0, 0, 0);
		wb(ba(8'h08), 1'b1, 0, 0);
		wb(ba(8'h05), 1'b1, 0, 0);
		repeat (80) @(posedge clk_i);
		`CHK(irq, 1'b0)
		wb(ba(8'h05), 1'b0, 0, 32'h0000_0001);
		wb(ba(8'h08), 1'b1, 1, 0);
		i = 0;
		while (irq !== 1'b1 && i < 80) begin @(posedge clk_i); i++; end
		`CHK(irq, 1'b1)
		wb(ba(8'h0e), 1'b1, 32'h0000_004b, 0);
		wb(ba(8'h0e), 1'b1, 32'h0000_0040, 0);
		wb(ba(8'h0e), 1'b0, 0, 32'h0000_004b);
		width(3, 4);
		wb(ba(8'h00), 1'b1, 32'h0000_0020, 0);
		width(6, P + 1);
		wb(ba(8'h00), 1'b1, 32'h0000_0032, 0);
		width(6, (P + 1) * 8);
		wb(ba(8'h00), 1'b1, 32'h0000_002b, 0);
		width(6, (P + 1) * 64);
		wb(ba(8'h0a), 1'b1, 0, 0);
		wb(ba(8'h0a), 1'b0, 0, 0);
		`CHK(oe, 6'h00)
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(ba(8'h18), 1'b0, 0, 32'h0000_ffff);
		ln = 4'h1;
		wb(ba(8'h18), 1'b1, 32'h0000_1234, 0);
		ln = 4'hf;
		wb(ba(8'h18), 1'b0, 0, 32'h0000_ff34);
		repeat (2) @(posedge clk_i);
		complete_run;
	end
endmodule // tb_top
